// [core/aje_exec.sv]
// Purpose: execution datapath for arithmetic, logic, multiply and jump operations
// Assumes: operands are staged by software over apb, then a command is written
// Notes:   busy until the documented cycle count has passed
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module aje_exec
  import aje_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  // status
  output logic             busy_out,
  output logic [15:0]      pc_out
);

  aje_state_s   st_reg;
  aje_state_s   st_next;
  aje_apb_req_s req;
  logic         wr_acc;
  logic         rd_acc;
  logic         mapped;
  logic [31:0]  rdata;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                 paddr: paddr_in, pwdata: pwdata_in};
  assign wr_acc = req.psel && req.penable && req.pwrite && clk_en_in;
  assign rd_acc = req.psel && req.penable && !req.pwrite;

  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (req.paddr)
      AJE_OFF_CMD:    rdata = {27'h0, st_reg.op};
      AJE_OFF_OPA:    rdata = {16'h0, st_reg.opa};
      AJE_OFF_OPB:    rdata = {16'h0, st_reg.opb};
      AJE_OFF_FLAGS:  rdata = {24'h0, st_reg.flags};
      AJE_OFF_RESULT: rdata = {16'h0, st_reg.result};
      AJE_OFF_PC:     rdata = {16'h0, st_reg.pc};
      AJE_OFF_STATUS: rdata = {29'h0, st_reg.bad_op, st_reg.done,
                               st_reg.state == AJE_ST_BUSY};
      AJE_OFF_SP:     rdata = {16'h0, st_reg.sp};
      default:        mapped = 1'b0;
    endcase
  end

  // writes take effect only when the clock is enabled, so stall otherwise
  assign pready_out  = clk_en_in;
  assign pslverr_out = req.psel && req.penable && !mapped;
  assign busy_out    = st_reg.state == AJE_ST_BUSY;
  assign pc_out      = st_reg.pc;

  ////////////////////////////////////////////////////////////////////////////
  // datapath
  logic [7:0]  a8;
  logic [7:0]  b8;
  logic [7:0]  r8;
  logic [8:0]  sum9;
  logic [4:0]  nib;
  logic [16:0] w17;
  logic [15:0] prod;
  logic [15:0] prod_out;
  logic [1:0]  ncyc;
  logic        cin;
  logic        logic_op;
  logic        arith8;
  logic        is_sub;
  logic        is_mul;
  logic        is_frac;

  always_comb begin
    a8       = st_reg.opa[7:0];
    b8       = st_reg.opb[7:0];
    cin      = st_reg.flags[AJE_FLAG_C];
    sum9     = 9'h000;
    nib      = 5'h00;
    w17      = 17'h00000;
    prod     = 16'h0000;
    prod_out = 16'h0000;
    r8       = 8'h00;
    logic_op = 1'b0;
    arith8   = 1'b0;
    is_sub   = 1'b0;
    is_mul   = 1'b0;
    is_frac  = 1'b0;
    case (st_reg.op)
      AJE_OP_ADD, AJE_OP_ADD_CARRY: begin
        arith8 = 1'b1;
        sum9 = {1'b0, a8} + {1'b0, b8} + {8'h00, st_reg.op == AJE_OP_ADD_CARRY && cin};
        nib  = {1'b0, a8[3:0]} + {1'b0, b8[3:0]}
               + {4'h0, st_reg.op == AJE_OP_ADD_CARRY && cin};
      end
      AJE_OP_SUB, AJE_OP_SUB_CONSTANT, AJE_OP_SUB_WITH_BORROW,
      AJE_OP_SUB_BORROW_CONSTANT: begin
        arith8 = 1'b1;
        is_sub = 1'b1;
        sum9 = {1'b0, a8} - {1'b0, b8} - {8'h00, cin &&
               (st_reg.op == AJE_OP_SUB_WITH_BORROW || st_reg.op == AJE_OP_SUB_BORROW_CONSTANT)};
        nib  = {1'b0, a8[3:0]} - {1'b0, b8[3:0]} - {4'h0, cin &&
               (st_reg.op == AJE_OP_SUB_WITH_BORROW || st_reg.op == AJE_OP_SUB_BORROW_CONSTANT)};
      end
      AJE_OP_WORD_ADD_IMMEDIATE: w17 = {1'b0, st_reg.opa} + {11'h000, st_reg.opb[5:0]};
      AJE_OP_WORD_SUB_IMMEDIATE: w17 = {1'b0, st_reg.opa} - {11'h000, st_reg.opb[5:0]};
      AJE_OP_AND, AJE_OP_AND_WITH_CONSTANT: begin
        logic_op = 1'b1;
        r8 = a8 & b8;
      end
      AJE_OP_OR, AJE_OP_OR_WITH_CONSTANT, AJE_OP_SET_BITS: begin
        logic_op = 1'b1;
        r8 = a8 | b8;
      end
      AJE_OP_EXCLUSIVE_OR: begin
        logic_op = 1'b1;
        r8 = a8 ^ b8;
      end
      AJE_OP_CLEAR_BITS: begin
        logic_op = 1'b1;
        r8 = a8 & (AJE_MASK_ALL - b8);
      end
      AJE_OP_TEST_VALUE: begin
        logic_op = 1'b1;
        r8 = a8 & a8;
      end
      AJE_OP_UNSIGNED_PRODUCT, AJE_OP_FRAC_UNSIGNED_PRODUCT: begin
        is_mul = 1'b1;
        prod = {8'h00, a8} * {8'h00, b8};
      end
      AJE_OP_SIGNED_PRODUCT, AJE_OP_FRAC_SIGNED_PRODUCT: begin
        is_mul = 1'b1;
        prod = 16'($signed({{8{a8[7]}}, a8}) * $signed({{8{b8[7]}}, b8}));
      end
      AJE_OP_SIGNED_UNSIGNED_PRODUCT, AJE_OP_FRACTIONAL_SIGNED_UNSIGNED_PRODUCT: begin
        is_mul = 1'b1;
        prod = 16'($signed({{8{a8[7]}}, a8}) * $signed({8'h00, b8}));
      end
      default: begin
      end
    endcase
    is_frac = st_reg.op == AJE_OP_FRAC_UNSIGNED_PRODUCT
           || st_reg.op == AJE_OP_FRAC_SIGNED_PRODUCT
           || st_reg.op == AJE_OP_FRACTIONAL_SIGNED_UNSIGNED_PRODUCT;
    prod_out = is_frac ? {prod[14:0], 1'b0} : prod;
    if (arith8) begin
      r8 = sum9[7:0];
    end
  end

  // cycle count per opcode
  always_comb begin
    case (aje_op_e'(pwdata_in[4:0]))
      AJE_OP_WORD_ADD_IMMEDIATE, AJE_OP_WORD_SUB_IMMEDIATE,
      AJE_OP_UNSIGNED_PRODUCT, AJE_OP_SIGNED_PRODUCT, AJE_OP_SIGNED_UNSIGNED_PRODUCT,
      AJE_OP_FRAC_UNSIGNED_PRODUCT, AJE_OP_FRAC_SIGNED_PRODUCT,
      AJE_OP_FRACTIONAL_SIGNED_UNSIGNED_PRODUCT,
      AJE_OP_RELATIVE_JUMP, AJE_OP_INDIRECT_JUMP: ncyc = AJE_CYC_TWO;
      AJE_OP_DIRECT_JUMP, AJE_OP_RELATIVE_CALL,
      AJE_OP_INDIRECT_CALL, AJE_OP_DIRECT_CALL: ncyc = AJE_CYC_THREE;
      default: ncyc = AJE_CYC_ONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next          = st_reg;
    st_next.ret_push = 1'b0;
    case (st_reg.state)
      AJE_ST_IDLE: begin
        if (wr_acc) begin
          case (req.paddr)
            AJE_OFF_OPA:   st_next.opa = req.pwdata[15:0];
            AJE_OFF_OPB:   st_next.opb = req.pwdata[15:0];
            AJE_OFF_FLAGS: st_next.flags = req.pwdata[7:0];
            AJE_OFF_PC:    st_next.pc = req.pwdata[15:0];
            AJE_OFF_SP:    st_next.sp = req.pwdata[15:0];
            AJE_OFF_CMD: begin
              st_next.bad_op = req.pwdata[4:0] > 5'(AJE_OP_DIRECT_CALL);
              if (!st_next.bad_op) begin
                st_next.op    = aje_op_e'(req.pwdata[4:0]);
                st_next.cnt   = ncyc;
                st_next.done  = 1'b0;
                st_next.state = AJE_ST_BUSY;
              end
            end
            default: begin
            end
          endcase
        end
      end
      AJE_ST_BUSY: begin
        st_next.cnt = st_reg.cnt - 2'h1;
        if (st_reg.cnt == AJE_CYC_ONE) begin
          st_next.state = AJE_ST_IDLE;
          st_next.done  = 1'b1;
          if (arith8) begin
            st_next.result = {8'h00, r8};
            st_next.flags[AJE_FLAG_Z] = r8 == 8'h00;
            st_next.flags[AJE_FLAG_N] = r8[7];
            st_next.flags[AJE_FLAG_C] = sum9[8];
            st_next.flags[AJE_FLAG_H] = nib[4];
            st_next.flags[AJE_FLAG_V] = is_sub ? (a8[7] != b8[7]) && (r8[7] != a8[7])
                                              : (a8[7] == b8[7]) && (r8[7] != a8[7]);
          end else if (logic_op) begin
            st_next.result = {8'h00, r8};
            st_next.flags[AJE_FLAG_Z] = r8 == 8'h00;
            st_next.flags[AJE_FLAG_N] = r8[7];
            st_next.flags[AJE_FLAG_V] = 1'b0;
          end else if (is_mul) begin
            st_next.result = prod_out;
            st_next.flags[AJE_FLAG_Z] = prod_out == 16'h0000;
            st_next.flags[AJE_FLAG_C] = prod[15];
          end
          case (st_reg.op)
            AJE_OP_WORD_ADD_IMMEDIATE, AJE_OP_WORD_SUB_IMMEDIATE: begin
              st_next.result = w17[15:0];
              st_next.flags[AJE_FLAG_Z] = w17[15:0] == 16'h0000;
              st_next.flags[AJE_FLAG_N] = w17[15];
              st_next.flags[AJE_FLAG_C] = w17[16];
              st_next.flags[AJE_FLAG_V] = (st_reg.op == AJE_OP_WORD_ADD_IMMEDIATE)
                                          ? (!st_reg.opa[15] && w17[15])
                                          : (st_reg.opa[15] && !w17[15]);
              st_next.flags[AJE_FLAG_S] = w17[15] ^ st_next.flags[AJE_FLAG_V];
            end
            AJE_OP_RELATIVE_JUMP, AJE_OP_RELATIVE_CALL:
              st_next.pc = st_reg.pc + st_reg.opb + 16'h0001;
            AJE_OP_DIRECT_JUMP, AJE_OP_DIRECT_CALL:
              st_next.pc = st_reg.opb;
            AJE_OP_INDIRECT_JUMP, AJE_OP_INDIRECT_CALL:
              st_next.pc = st_reg.opa;
            default: begin
            end
          endcase
        end else if (st_reg.cnt == AJE_CYC_THREE && st_reg.op != AJE_OP_DIRECT_JUMP) begin
          // calls push the return address in their first busy cycle
          st_next.ret_addr = st_reg.pc + 16'h0001;
          st_next.ret_push = 1'b1;
          st_next.sp       = st_reg.sp - 16'h0002;
        end
      end
      default: st_next.state = AJE_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg       <= '0;
      st_reg.state <= AJE_ST_IDLE;
      st_reg.flags <= AJE_FLAGS_RST;
      st_reg.pc    <= AJE_PC_RST;
      st_reg.sp    <= AJE_SP_RST;
    end else if (clk_en_in) begin
      st_reg <= st_next;
    end
  end

  assign prdata_out = rd_acc ? rdata : 32'h0000_0000;

endmodule : aje_exec

// [core/aje_pkg.sv]
// Purpose: shared constants and types for the execution datapath
// Assumes: 8-bit core, 16-bit program counter
// Notes:   register offsets are byte addresses on the apb slave
package aje_pkg;

  // apb register offsets
  localparam logic [7:0] AJE_OFF_CMD    = 8'h00;
  localparam logic [7:0] AJE_OFF_OPA    = 8'h04;
  localparam logic [7:0] AJE_OFF_OPB    = 8'h08;
  localparam logic [7:0] AJE_OFF_FLAGS  = 8'h0C;
  localparam logic [7:0] AJE_OFF_RESULT = 8'h10;
  localparam logic [7:0] AJE_OFF_PC     = 8'h14;
  localparam logic [7:0] AJE_OFF_STATUS = 8'h18;
  localparam logic [7:0] AJE_OFF_SP     = 8'h1C;

  // flag field positions
  localparam int AJE_FLAG_C = 0;
  localparam int AJE_FLAG_Z = 1;
  localparam int AJE_FLAG_N = 2;
  localparam int AJE_FLAG_V = 3;
  localparam int AJE_FLAG_S = 4;
  localparam int AJE_FLAG_H = 5;

  // reset values and the all-ones byte mask
  localparam logic [7:0]  AJE_FLAGS_RST = 8'h00;
  localparam logic [15:0] AJE_PC_RST    = 16'h0000;
  localparam logic [15:0] AJE_SP_RST    = 16'h00FF;
  localparam logic [7:0]  AJE_MASK_ALL  = 8'hFF;

  // cycle counts
  localparam logic [1:0] AJE_CYC_ONE   = 2'h1;
  localparam logic [1:0] AJE_CYC_TWO   = 2'h2;
  localparam logic [1:0] AJE_CYC_THREE = 2'h3;

  // opcodes written to the command register
  typedef enum logic [4:0] {
    AJE_OP_ADD, AJE_OP_ADD_CARRY, AJE_OP_WORD_ADD_IMMEDIATE, AJE_OP_SUB,
    AJE_OP_SUB_CONSTANT, AJE_OP_SUB_WITH_BORROW, AJE_OP_SUB_BORROW_CONSTANT,
    AJE_OP_WORD_SUB_IMMEDIATE, AJE_OP_AND, AJE_OP_AND_WITH_CONSTANT, AJE_OP_OR,
    AJE_OP_OR_WITH_CONSTANT, AJE_OP_EXCLUSIVE_OR, AJE_OP_SET_BITS, AJE_OP_CLEAR_BITS,
    AJE_OP_TEST_VALUE, AJE_OP_UNSIGNED_PRODUCT, AJE_OP_SIGNED_PRODUCT,
    AJE_OP_SIGNED_UNSIGNED_PRODUCT, AJE_OP_FRAC_UNSIGNED_PRODUCT,
    AJE_OP_FRAC_SIGNED_PRODUCT, AJE_OP_FRACTIONAL_SIGNED_UNSIGNED_PRODUCT,
    AJE_OP_RELATIVE_JUMP, AJE_OP_INDIRECT_JUMP, AJE_OP_DIRECT_JUMP,
    AJE_OP_RELATIVE_CALL, AJE_OP_INDIRECT_CALL, AJE_OP_DIRECT_CALL
  } aje_op_e;

  typedef enum logic [1:0] {AJE_ST_IDLE, AJE_ST_BUSY} aje_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } aje_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } aje_apb_rsp_s;

  // whole state of the datapath
  typedef struct packed {
    aje_state_e  state;
    aje_op_e     op;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [7:0]  flags;
    logic [15:0] result;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] ret_addr;
    logic        ret_push;
    logic [1:0]  cnt;
    logic        done;
    logic        bad_op;
  } aje_state_s;

endpackage : aje_pkg

// [tb/aje_exec_properties.sv]
// Purpose: port checks for the execution datapath
// Assumes: zero-wait apb, clock enable high while an operation runs
// Notes:   bound into every aje_exec
module aje_exec_properties
  import aje_pkg::*;
(
  // clock, reset and apb request
  input wire logic        clock_in,
  input wire logic        reset_n_in,
  input wire logic        clk_en_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  // answers and status
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [31:0] prdata_out,
  input wire logic        busy_out,
  input wire logic [15:0] pc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////
  logic [4:0] op_w;
  logic       acc;
  logic       cmd_w;
  logic       c1;
  logic       c2;
  logic       c3;
  assign op_w  = pwdata_in[4:0];
  assign acc   = psel_in && penable_in;
  assign cmd_w = acc && pwrite_in && clk_en_in && paddr_in == AJE_OFF_CMD;
  assign c2    = op_w inside {5'h02, 5'h07, [5'h10:5'h17]};
  assign c3    = op_w inside {[5'h18:5'h1B]};
  assign c1    = op_w <= 5'h0F && !c2;
  sequence s_cmd;
    cmd_w && !busy_out;
  endsequence
  sequence s_one;
    busy_out ##1 !busy_out;
  endsequence
  sequence s_two;
    busy_out [*2] ##1 !busy_out;
  endsequence
  sequence s_three;
    busy_out [*3] ##1 !busy_out;
  endsequence
  ////////////////////////////////////////
  AST_RUN_ONE: assert property (s_cmd ##0 c1 |=> s_one)
    else $error("one-cycle op has wrong length");
  AST_RUN_TWO: assert property (s_cmd ##0 c2 |=> s_two)
    else $error("two-cycle op has wrong length");
  AST_RUN_THREE: assert property (s_cmd ##0 c3 |=> s_three)
    else $error("three-cycle op has wrong length");
  AST_BAD_OP: assert property (s_cmd ##0 op_w > 5'h1B |=> !busy_out [*2])
    else $error("unknown command started an op");
  AST_START: assert property ($rose(busy_out) |-> $past(cmd_w))
    else $error("busy rose without a command");
  AST_PC_HOLD: assert property (!busy_out && !$past(busy_out) |-> $stable(pc_out))
    else $error("pc moved while idle");
  AST_UNMAPPED: assert property (acc && (paddr_in > 8'h1C || paddr_in[1:0] != 2'h0)
    |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  AST_RD_IDLE: assert property (!acc |-> prdata_out == 32'h0 && !pslverr_out)
    else $error("read data outside access phase");
  AST_READY: assert property (pready_out == clk_en_in)
    else $error("ready does not follow clock enable");
endmodule : aje_exec_properties

bind aje_exec aje_exec_properties u_props (
  .clock_in, .reset_n_in, .clk_en_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .busy_out, .pc_out
);

// [tb/aje_host.sv]
// Purpose: decoder-side apb requester for the datapath
// Assumes: requests change only after a rising edge
// Notes:   released lines show the inverse of the last value
module aje_host
  import aje_pkg::*;
(
  // clock
  input  wire logic         clock_in,
  // apb request and answer
  output aje_apb_req_s      req_out,
  input  wire aje_apb_rsp_s rsp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_late = 0;
  initial req_out = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clock_in);
    req_out <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock_in);
    req_out.penable <= 1'b1;
    // hold the request until ready is seen high at a rising edge
    @(posedge clock_in);
    while (rsp_in.pready !== 1'b1 && n < 64) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 64) n_late++;
    q = rsp_in.prdata;
    e = rsp_in.pslverr;
    req_out <= '{1'b0, 1'b0, ~w, ~a, ~d};
  endtask : xfer
endmodule : aje_host

// [tb/testbench.sv]
// Purpose: self-checking bench for the execution datapath
// Assumes: zero-wait apb slave, status polled for completion
// Notes:   cycle counts are checked by the bound properties
module testbench
  import aje_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clock_in;
  logic         reset_n_in;
  logic         clk_en_in;
  aje_apb_req_s req;
  aje_apb_rsp_s rsp;
  logic         busy;
  logic [15:0]  pc;
  logic [31:0]  q;
  logic         e;
  int           n_mismatch = 0;
  int           n_tests = 0;
  aje_host u_host (.clock_in, .req_out(req), .rsp_in(rsp));
  aje_exec dut (.clock_in, .reset_n_in, .clk_en_in, .psel_in(req.psel),
    .penable_in(req.penable), .pwrite_in(req.pwrite), .paddr_in(req.paddr),
    .pwdata_in(req.pwdata), .pready_out(rsp.pready), .pslverr_out(rsp.pslverr),
    .prdata_out(rsp.prdata), .busy_out(busy), .pc_out(pc));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    n_mismatch += u_host.n_late;
    $display("compares=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    u_host.xfer(1'b0, a, 32'h0, d, e);
    if (u_host.n_late > 0) close_out();
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
    if (u_host.n_late > 0) close_out();
  endtask : wr
  task automatic poll();
    int n;
    n = 0;
    rd(AJE_OFF_STATUS, q);
    while (q[0] !== 1'b0 && n < 16) begin
      rd(AJE_OFF_STATUS, q);
      n++;
    end
    if (n >= 16) begin
      n_mismatch++;
      close_out();
    end
  endtask : poll
  task automatic run(input aje_op_e op, input logic [15:0] a, input logic [15:0] b,
                     input logic [7:0] f);
    wr(AJE_OFF_OPA, {16'h0, a});
    wr(AJE_OFF_OPB, {16'h0, b});
    wr(AJE_OFF_FLAGS, {24'h0, f});
    wr(AJE_OFF_CMD, {27'h0, op});
    poll();
  endtask : run
  // expected {flags, result} of arithmetic, logic and multiply codes
  function automatic logic [23:0] model(input logic [4:0] op, input logic [15:0] a,
                                        input logic [15:0] b, input logic [7:0] f);
    logic [16:0] r;
    logic [4:0]  h;
    logic [7:0]  g;
    logic        ci;
    logic        ad;
    logic        w;
    g  = f;
    ci = f[AJE_FLAG_C] && op inside {5'h01, 5'h05, 5'h06};
    ad = op <= 5'h02;
    w  = op inside {5'h02, 5'h07} || op >= 5'h10;
    if (op <= 5'h06 && op != 5'h02) begin
      r = ad ? a[7:0] + b[7:0] + ci : a[7:0] - b[7:0] - ci;
      h = ad ? a[3:0] + b[3:0] + ci : a[3:0] - b[3:0] - ci;
      g[AJE_FLAG_C] = r[8];
      g[AJE_FLAG_H] = h[4];
      g[AJE_FLAG_V] = (a[7] ^ b[7] ^ ad) & (r[7] ^ a[7]);
    end else if (op == 5'h02 || op == 5'h07) begin
      r = ad ? a + b[5:0] : a - b[5:0];
      g[AJE_FLAG_C] = r[16];
      g[AJE_FLAG_V] = (r[15] ^ a[15]) & (r[15] == ad);
      g[AJE_FLAG_S] = r[15] ^ g[AJE_FLAG_V];
    end else if (op <= 5'h0F) begin
      case (op)
        5'h08, 5'h09:        r = a[7:0] & b[7:0];
        5'h0A, 5'h0B, 5'h0D: r = a[7:0] | b[7:0];
        5'h0C:               r = a[7:0] ^ b[7:0];
        5'h0E:               r = a[7:0] & ~b[7:0];
        default:             r = a[7:0];
      endcase
      g[AJE_FLAG_V] = 1'b0;
    end else begin
      case (op)
        5'h10, 5'h13: r = a[7:0] * b[7:0];
        5'h11, 5'h14: r = $signed(a[7:0]) * $signed(b[7:0]);
        default:      r = $signed(a[7:0]) * $signed({1'b0, b[7:0]});
      endcase
      g[AJE_FLAG_C] = r[15];
      if (op >= 5'h13) r = {1'b0, r[14:0], 1'b0};
    end
    if (!w) r[16:8] = '0;
    g[AJE_FLAG_Z] = r[15:0] == 16'h0;
    if (op < 5'h10) g[AJE_FLAG_N] = w ? r[15] : r[7];
    return {g, r[15:0]};
  endfunction : model
  ////////////////////////////////////////
  task automatic t_reset();
    rd(AJE_OFF_FLAGS, q);
    chk(q, {24'h0, AJE_FLAGS_RST});
    rd(AJE_OFF_PC, q);
    chk(q, {16'h0, AJE_PC_RST});
    rd(AJE_OFF_SP, q);
    chk(q, {16'h0, AJE_SP_RST});
    rd(AJE_OFF_STATUS, q);
    chk(q, 32'h0);
    rd(8'h20, q);
    chk({e, q[30:0]}, 32'h80000000);
  endtask : t_reset
  task automatic t_alu();
    logic [15:0] av [2] = '{16'hFFFF, 16'h8080};
    logic [15:0] bv [2] = '{16'h0001, 16'h00C1};
    logic [7:0]  fv [2] = '{8'h3F, 8'h02};
    logic [23:0] ex;
    logic [31:0] m;
    for (int i = 0; i < 22; i++) begin
      for (int s = 0; s < 2; s++) begin
        run(aje_op_e'(i), av[s], bv[s], fv[s]);
        ex = model(5'(i), av[s], bv[s], fv[s]);
        m = (i inside {2, 7} || i >= 16) ? 32'h0000FFFF : 32'h000000FF;
        rd(AJE_OFF_RESULT, q);
        chk(q & m, {16'h0, ex[15:0]} & m);
        rd(AJE_OFF_FLAGS, q);
        chk(q & 32'hFF, {24'h0, ex[23:16]});
      end
    end
  endtask : t_alu
  task automatic t_jump();
    aje_op_e     ov [6] = '{AJE_OP_DIRECT_JUMP, AJE_OP_RELATIVE_JUMP, AJE_OP_INDIRECT_JUMP,
                            AJE_OP_INDIRECT_CALL, AJE_OP_RELATIVE_CALL, AJE_OP_DIRECT_CALL};
    logic [15:0] av [6] = '{16'h0, 16'h0, 16'h0777, 16'h0500, 16'h0, 16'h0};
    logic [15:0] bv [6] = '{16'h1234, 16'hFFFE, 16'h0, 16'h0, 16'h0010, 16'h0042};
    logic [15:0] p;
    logic [15:0] sp;
    p  = 16'h0;
    sp = AJE_SP_RST;
    for (int i = 0; i < 6; i++) begin
      run(ov[i], av[i], bv[i], 8'h2A);
      case (ov[i])
        AJE_OP_DIRECT_JUMP, AJE_OP_DIRECT_CALL:     p = bv[i];
        AJE_OP_RELATIVE_JUMP, AJE_OP_RELATIVE_CALL: p = p + bv[i] + 16'h0001;
        default:                                    p = av[i];
      endcase
      if (i >= 3) sp = sp - 16'h0002;
      rd(AJE_OFF_PC, q);
      chk(q, {16'h0, p});
      chk({16'h0, pc}, {16'h0, p});
      rd(AJE_OFF_SP, q);
      chk(q, {16'h0, sp});
      rd(AJE_OFF_FLAGS, q);
      chk(q & 32'hFF, 32'h2A);
    end
  endtask : t_jump
  task automatic t_busy_bad();
    wr(AJE_OFF_OPA, 32'h00000777);
    wr(AJE_OFF_OPB, 32'h00004321);
    wr(AJE_OFF_CMD, {27'h0, AJE_OP_DIRECT_JUMP});
    wr(AJE_OFF_CMD, {27'h0, AJE_OP_INDIRECT_JUMP});
    poll();
    rd(AJE_OFF_PC, q);
    chk(q, 32'h00004321);
    wr(AJE_OFF_CMD, 32'h0000001F);
    rd(AJE_OFF_STATUS, q);
    chk({30'h0, q[2], q[0]}, 32'h2);
  endtask : t_busy_bad
  task automatic t_freeze_reset();
    @(posedge clock_in);
    clk_en_in <= 1'b0;
    @(negedge clock_in);
    chk({31'h0, rsp.pready}, 32'h0);
    @(posedge clock_in);
    clk_en_in <= 1'b1;
    wr(AJE_OFF_CMD, {27'h0, AJE_OP_INDIRECT_CALL});
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk({15'h0, busy, pc}, 32'h0);
    reset_n_in <= 1'b1;
    rd(AJE_OFF_SP, q);
    chk(q, {16'h0, AJE_SP_RST});
  endtask : t_freeze_reset
  ////////////////////////////////////////
  initial begin
    reset_n_in = 1'b0;
    clk_en_in  = 1'b1;
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_alu();
    t_jump();
    t_busy_bad();
    t_freeze_reset();
    close_out();
  end
endmodule : testbench
